/* common/csf_pkg.sv */
// Constants for the status word and arithmetic datapath block.
// Assumes a single system clock and an active-low asynchronous reset.
`default_nettype none
package csf_pkg;
	// ****************************************
	// Status word bit positions
	// ****************************************
	localparam int unsigned FLG_C = 0;
	localparam int unsigned FLG_Z = 1;
	localparam int unsigned FLG_I = 2;
	localparam int unsigned FLG_D = 3;
	localparam int unsigned FLG_B = 4;
	localparam int unsigned FLG_T = 5;
	localparam int unsigned FLG_V = 6;
	localparam int unsigned FLG_N = 7;
	localparam logic [7:0] PSW_RST = 8'h04;
	// ****************************************
	// Operation codes of the datapath
	// ****************************************
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_ADC = 4'h1;
	localparam logic [3:0] OP_SBC = 4'h2;
	localparam logic [3:0] OP_MUL = 4'h3;
	localparam logic [3:0] OP_DIV = 4'h4;
	localparam logic [3:0] OP_SEC = 4'h5;
	localparam logic [3:0] OP_CLC = 4'h6;
	localparam logic [3:0] OP_CLD = 4'h7;
	localparam logic [3:0] OP_SED = 4'h8;
	localparam logic [3:0] OP_PSW = 4'h9;
	localparam logic [3:0] OP_IRQW = 4'hA;
	localparam logic [3:0] OP_IRQR = 4'hB;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_DIV_HS = 2;
	localparam int unsigned IRQ_DELAY = 1;
endpackage : csf_pkg
`default_nettype wire

/* common/csf_op_if.sv */
// Operation carrier between the core top and its arithmetic unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface csf_op_if;
	logic [3:0] op;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic dec;
	logic [7:0] res;
	logic [7:0] res_hi;
	logic c_out;
	logic v_out;
	modport core (output op, a, b, cin, dec, input res, res_hi, c_out, v_out);
	modport alu (input op, a, b, cin, dec, output res, res_hi, c_out, v_out);
endinterface : csf_op_if
`default_nettype wire

/* hdl/csf_alu.sv */
// Combinational arithmetic unit: binary/BCD add and subtract, multiply,
// divide. Assumes operands are stable while the core samples the result.
`timescale 1ns/1ps
`default_nettype none
module csf_alu (
	// Operation link
	csf_op_if.alu op_if
);
	// ****************************************
	// Binary and BCD arithmetic
	// ****************************************
	logic [8:0] bin_add;
	logic [8:0] bin_sub;
	logic [4:0] lo_a;
	logic [4:0] lo_s;
	logic lo_ac;
	logic lo_sb;
	logic [4:0] hi_a;
	logic [4:0] hi_s;
	logic hi_ac;
	logic hi_sb;
	logic [3:0] lo_ad;
	logic [3:0] lo_sd;
	logic [3:0] hi_ad;
	logic [3:0] hi_sd;
	logic [15:0] prod;
	logic [7:0] quo;
	logic [7:0] rem;
	logic div_ok;
	logic is_add;
	logic is_sub;

	// Binary sums with carry or borrow
	assign bin_add = {1'b0, op_if.a} + {1'b0, op_if.b} + {8'h00, op_if.cin};
	assign bin_sub = {1'b0, op_if.a} - {1'b0, op_if.b} - {8'h00, ~op_if.cin};

	// Decimal nibble adjust, low digit then high digit
	assign lo_a = {1'b0, op_if.a[3:0]} + {1'b0, op_if.b[3:0]} + {4'h0, op_if.cin};
	assign lo_ac = lo_a > 5'h09;
	assign lo_ad = lo_ac ? 4'((lo_a + 5'h06) & 5'h0F) : lo_a[3:0];
	assign hi_a = {1'b0, op_if.a[7:4]} + {1'b0, op_if.b[7:4]} + {4'h0, lo_ac};
	assign hi_ac = hi_a > 5'h09;
	assign hi_ad = hi_ac ? 4'((hi_a + 5'h06) & 5'h0F) : hi_a[3:0];
	assign lo_s = {1'b0, op_if.a[3:0]} - {1'b0, op_if.b[3:0]} - {4'h0, ~op_if.cin};
	assign lo_sb = lo_s[4];
	assign lo_sd = lo_sb ? 4'(lo_s - 5'h06) : lo_s[3:0];
	assign hi_s = {1'b0, op_if.a[7:4]} - {1'b0, op_if.b[7:4]} - {4'h0, lo_sb};
	assign hi_sb = hi_s[4];
	assign hi_sd = hi_sb ? 4'(hi_s - 5'h06) : hi_s[3:0];

	// Multiply and divide take no notice of the mode flags
	assign prod = {8'h00, op_if.a} * {8'h00, op_if.b};
	assign div_ok = op_if.b != 8'h00;
	assign quo = div_ok ? op_if.a / op_if.b : 8'hFF;
	assign rem = div_ok ? op_if.a % op_if.b : op_if.a;

	// Result selection
	assign is_add = op_if.op == csf_pkg::OP_ADC;
	assign is_sub = op_if.op == csf_pkg::OP_SBC;
	assign op_if.res = is_add ? (op_if.dec ? {hi_ad, lo_ad} : bin_add[7:0])
		: is_sub ? (op_if.dec ? {hi_sd, lo_sd} : bin_sub[7:0])
		: (op_if.op == csf_pkg::OP_MUL) ? prod[7:0]
		: (op_if.op == csf_pkg::OP_DIV) ? quo : 8'h00;
	assign op_if.res_hi = (op_if.op == csf_pkg::OP_MUL) ? prod[15:8]
		: (op_if.op == csf_pkg::OP_DIV) ? rem : 8'h00;
	assign op_if.c_out = is_add ? (op_if.dec ? hi_ac : bin_add[8])
		: (op_if.dec ? ~hi_sb : ~bin_sub[8]);
	// Overflow from sign bits, binary mode only is meaningful
	assign op_if.v_out = is_add
		? (op_if.a[7] == op_if.b[7]) && (bin_add[7] != op_if.a[7])
		: (op_if.a[7] != op_if.b[7]) && (bin_sub[7] != op_if.a[7]);
endmodule : csf_alu
`default_nettype wire

/* hdl/csf_core.sv */
// Core status word, arithmetic sequencing, interrupt request latch and
// internal clock divider. Assumes one instruction request per accepted
// strobe from the decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none
module csf_core #(
	parameter int unsigned IRQ_W = 8
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Instruction request
	input wire logic op_vld_i,
	input wire logic [3:0] op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic [7:0] psw_wr_i,
	input wire logic [IRQ_W-1:0] irq_wr_i,
	input wire logic [IRQ_W-1:0] irq_set_i,
	input wire logic high_speed_i,
	// Results and state
	output logic [7:0] res_o,
	output logic [7:0] res_hi_o,
	output logic [7:0] processor_status_word_o,
	output logic [IRQ_W-1:0] irq_req_o,
	output logic dec_hazard_o,
	output logic done_o,
	output logic phi_o
);
	// ****************************************
	// Datapath link
	// ****************************************
	csf_op_if op_if ();
	csf_alu u_alu (
		.op_if(op_if)
	);

	// Registers
	logic [7:0] psw_r;
	logic [7:0] psw_nxt;
	logic [7:0] res_r;
	logic [7:0] res_hi_r;
	logic [IRQ_W-1:0] irq_r;
	logic [IRQ_W-1:0] irq_pend_r;
	logic irq_pend_vld_r;
	logic dec_last_r;
	logic haz_r;
	logic done_r;
	logic phi_r;

	// Decoded request classes
	logic [3:0] op_code;
	logic is_arith;
	logic is_muldiv;
	logic is_flag;
	logic is_irq_wr;
	wire logic [IRQ_W-1:0] irq_nxt;

	// ****************************************
	// Operation decoding
	// ****************************************
	// Add and subtract, the two ops with a decimal variant
	function automatic logic op_is_arith(input logic [3:0] code);
		return code == csf_pkg::OP_ADC || code == csf_pkg::OP_SBC;
	endfunction : op_is_arith

	// Multiply and divide, which never touch the status word
	function automatic logic op_is_muldiv(input logic [3:0] code);
		return code == csf_pkg::OP_MUL || code == csf_pkg::OP_DIV;
	endfunction : op_is_muldiv

	// Flag ops that are unsafe right after decimal arithmetic
	function automatic logic op_is_flag(input logic [3:0] code);
		return code == csf_pkg::OP_SEC || code == csf_pkg::OP_CLC
			|| code == csf_pkg::OP_CLD;
	endfunction : op_is_flag

	// An idle strobe is presented to the datapath as a no-op
	assign op_code = op_vld_i ? op_i : csf_pkg::OP_NOP;
	assign is_arith = op_is_arith(op_code);
	assign is_muldiv = op_is_muldiv(op_code);
	assign is_flag = op_is_flag(op_code);
	assign is_irq_wr = op_code == csf_pkg::OP_IRQW;

	// Operands and mode flags towards the arithmetic unit
	assign op_if.op = op_code;
	assign op_if.a = a_i;
	assign op_if.b = b_i;
	assign op_if.cin = psw_r[csf_pkg::FLG_C];
	assign op_if.dec = psw_r[csf_pkg::FLG_D];

	// ****************************************
	// Status word next value
	// ****************************************
	always_comb begin
		psw_nxt = psw_r;
		if (is_arith) begin
			psw_nxt[csf_pkg::FLG_C] = op_if.c_out;
			// Decimal results leave N, V and Z with no defined meaning
			psw_nxt[csf_pkg::FLG_N] = op_if.res[7];
			psw_nxt[csf_pkg::FLG_Z] = op_if.res == 8'h00;
			psw_nxt[csf_pkg::FLG_V] = op_if.v_out;
		end else if (is_muldiv) begin
			// Multiply and divide report through the result only
			psw_nxt = psw_r;
		end else if (op_vld_i) begin
			// Flag ops and status loads; other codes leave the word alone
			unique case (op_i)
				csf_pkg::OP_SEC: psw_nxt[csf_pkg::FLG_C] = 1'b1;
				csf_pkg::OP_CLC: psw_nxt[csf_pkg::FLG_C] = 1'b0;
				csf_pkg::OP_CLD: psw_nxt[csf_pkg::FLG_D] = 1'b0;
				csf_pkg::OP_SED: psw_nxt[csf_pkg::FLG_D] = 1'b1;
				csf_pkg::OP_PSW: psw_nxt = psw_wr_i;
				default: psw_nxt = psw_r;
			endcase
		end
	end

	// Status word register, reset loads I set and every other bit clear
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			psw_r <= csf_pkg::PSW_RST;
		end else begin
			psw_r <= psw_nxt;
		end
	end

	// ****************************************
	// Results and completion
	// ****************************************
	// Results of arithmetic, multiply and divide hold until the next one
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			res_r <= 8'h00;
			res_hi_r <= 8'h00;
		end else if (is_arith || is_muldiv) begin
			res_r <= op_if.res;
			res_hi_r <= op_if.res_hi;
		end
	end

	// One-cycle completion pulse for every accepted strobe
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_r <= 1'b0;
		end else begin
			done_r <= op_vld_i;
		end
	end

	// ****************************************
	// Decimal flag hazard
	// ****************************************
	// Remember whether the last accepted op was decimal arithmetic
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dec_last_r <= 1'b0;
		end else if (op_vld_i) begin
			dec_last_r <= is_arith && psw_r[csf_pkg::FLG_D];
		end
	end

	// A flag op right after decimal arithmetic is reported as unreliable
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			haz_r <= 1'b0;
		end else begin
			haz_r <= is_flag && dec_last_r;
		end
	end

	// ****************************************
	// Interrupt request bits with write delay
	// ****************************************
	// Written value waits one cycle before it reaches the request bits
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_pend_r <= '0;
			irq_pend_vld_r <= 1'b0;
		end else begin
			irq_pend_vld_r <= is_irq_wr;
			irq_pend_r <= irq_wr_i;
		end
	end

	// Per-bit next value; a hardware set wins over a written clear
	for (genvar g = 0; g < IRQ_W; g++) begin : g_irq
		assign irq_nxt[g] = irq_set_i[g]
			| (irq_pend_vld_r ? irq_pend_r[g] : irq_r[g]);
	end

	// Request bits register
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_r <= '0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// ****************************************
	// Internal clock
	// ****************************************
	// High-speed mode toggles every cycle: half the oscillator rate
	// Outside high-speed mode the phase holds; slower modes are not built
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phi_r <= 1'b0;
		end else if (high_speed_i) begin
			phi_r <= ~phi_r;
		end
	end

	// ****************************************
	// Outputs, each straight from a register
	// ****************************************
	assign res_o = res_r;
	assign res_hi_o = res_hi_r;
	assign processor_status_word_o = psw_r;
	assign irq_req_o = irq_r;
	assign dec_hazard_o = haz_r;
	assign done_o = done_r;
	assign phi_o = phi_r;
endmodule : csf_core
`default_nettype wire

/* test/csf_core_assertions.sv */
// Checker for csf_core, attached by bind after the module.
// Assumes one clock domain and the ports of csf_core.
`timescale 1ns/1ps
`default_nettype none
module csf_core_assertions #(
	parameter int unsigned IRQ_W = 8
) (
	// Clock, reset and requests
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic op_vld_i,
	input wire logic [3:0] op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic [IRQ_W-1:0] irq_wr_i,
	input wire logic [IRQ_W-1:0] irq_set_i,
	input wire logic high_speed_i,
	// Watched outputs
	input wire logic [7:0] res_o,
	input wire logic [7:0] res_hi_o,
	input wire logic [7:0] processor_status_word_o,
	input wire logic [IRQ_W-1:0] irq_req_o,
	input wire logic dec_hazard_o,
	input wire logic phi_o,
	input wire logic done_o
);
	// Request classes
	wire logic [7:0] psw = processor_status_word_o;
	wire logic [3:0] o = op_vld_i ? op_i : csf_pkg::OP_NOP;
	wire logic is_mul = o == csf_pkg::OP_MUL;
	wire logic is_div = o == csf_pkg::OP_DIV && b_i != 8'h00;
	wire logic is_flg = o == csf_pkg::OP_SEC || o == csf_pkg::OP_CLC ||
		o == csf_pkg::OP_CLD;
	wire logic is_dar = (o == csf_pkg::OP_ADC || o == csf_pkg::OP_SBC) &&
		psw[csf_pkg::FLG_D];
	wire logic is_irw = o == csf_pkg::OP_IRQW && irq_set_i == '0;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	property p_rst;
		$rose(rst_n_i) |-> psw[csf_pkg::FLG_I];
	endproperty
	a_rst: assert property (p_rst) else $error("I flag clear");
	property p_md;
		is_mul || o == csf_pkg::OP_DIV |=> $stable(psw);
	endproperty
	a_md: assert property (p_md) else $error("status changed");
	property p_mul;
		is_mul |=> {res_hi_o, res_o} == {8'h00, $past(a_i)} * $past(b_i);
	endproperty
	a_mul: assert property (p_mul) else $error("bad product");
	property p_div;
		is_div |=> res_o == $past(a_i) / $past(b_i) &&
			res_hi_o == $past(a_i) % $past(b_i);
	endproperty
	a_div: assert property (p_div) else $error("bad quotient");
	property p_hz;
		is_dar ##1 is_flg |=> dec_hazard_o;
	endproperty
	a_hz: assert property (p_hz) else $error("no hazard");
	property p_irq;
		is_irw && $past(irq_set_i) == '0 ##1 irq_set_i == '0 |->
			$stable(irq_req_o) ##1 irq_req_o == $past(irq_wr_i, 2);
	endproperty
	a_irq: assert property (p_irq) else $error("request timing");
	property p_phi;
		high_speed_i |=> phi_o != $past(phi_o);
	endproperty
	a_phi: assert property (p_phi) else $error("phi not toggling");
	property p_phi_hold;
		!high_speed_i |=> $stable(phi_o);
	endproperty
	a_phi_hold: assert property (p_phi_hold) else $error("phi moved");
	property p_hz_none;
		!is_flg |=> !dec_hazard_o;
	endproperty
	a_hz_none: assert property (p_hz_none) else $error("hazard");
	property p_done;
		op_vld_i |=> done_o;
	endproperty
	a_done: assert property (p_done) else $error("no done pulse");
	property p_done_low;
		!op_vld_i |=> !done_o;
	endproperty
	a_done_low: assert property (p_done_low) else $error("stray done");
endmodule : csf_core_assertions
bind csf_core csf_core_assertions #(.IRQ_W(IRQ_W)) u_chk (.clk_sys_i,
	.rst_n_i, .op_vld_i, .op_i, .a_i, .b_i, .irq_wr_i, .irq_set_i,
	.high_speed_i, .res_o, .res_hi_o, .processor_status_word_o,
	.irq_req_o, .dec_hazard_o, .phi_o, .done_o);
`default_nettype wire

/* test/csf_core_test.sv */
// Self-checking bench for csf_core: arithmetic, flags, requests, clock.
// Assumes csf_pkg, the interface, the design and the checker come first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module csf_core_test;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic op_vld_i = 1'b0;
	logic [3:0] op_i = 4'h0;
	logic [7:0] a_i = 8'h00, b_i = 8'h00, psw_wr_i = 8'h00;
	logic [7:0] irq_wr_i = 8'h00, irq_set_i = 8'h00;
	logic high_speed_i = 1'b0;
	logic [7:0] res_o, res_hi_o, psw_o, irq_req_o;
	logic dec_hazard_o, done_o, phi_o;
	int fail_count = 0;
	int checks = 0;
	// Status in, op, a, b, result, carry out
	logic [39:0] tv [8] = '{40'h0011928410, 40'h0811928470, 40'h0915846051,
		40'h0819901001, 40'h0924215271, 40'h0824215261, 40'h0921542730,
		40'h01210010F1};
	logic [7:0] pm [3] = '{8'h00, 8'h28, 8'hFF};
	// Flag op, bit position, value after
	logic [7:0] fo [3] = '{8'h51, 8'h60, 8'h76};
	csf_core #(.IRQ_W(8)) dut (.clk_sys_i, .rst_n_i, .op_vld_i, .op_i,
		.a_i, .b_i, .psw_wr_i, .irq_wr_i, .irq_set_i, .high_speed_i,
		.res_o, .res_hi_o, .processor_status_word_o(psw_o), .irq_req_o,
		.dec_hazard_o, .done_o, .phi_o);
	// System clock
	initial begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	// Present one op; strobe stays up so ops can run back to back
	task automatic issue(input logic [3:0] o, input logic [7:0] a,
		input logic [7:0] b);
		op_vld_i = 1'b1;
		op_i = o;
		a_i = a;
		b_i = b;
		@(negedge clk_sys_i);
	endtask : issue
	task automatic idle;
		op_vld_i = 1'b0;
		@(negedge clk_sys_i);
	endtask : idle
	task automatic ld(input logic [7:0] p);
		psw_wr_i = p;
		issue(csf_pkg::OP_PSW, 8'h00, 8'h00);
	endtask : ld
	task automatic give_verdict;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	// Hang guard, well past the expected run
	initial begin
		#100000;
		fail_count++;
		give_verdict();
	end
	// Main sequence
	initial begin
		int n;
		logic p;
		repeat (5) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		`CHK(psw_o[csf_pkg::FLG_I], 1'b1)
		foreach (tv[i]) begin
			ld(tv[i][39:32]);
			issue(tv[i][31:28], tv[i][27:20], tv[i][19:12]);
			`CHK(res_o, tv[i][11:4])
			`CHK(psw_o[csf_pkg::FLG_C], tv[i][0])
			`CHK(done_o, 1'b1)
		end
		foreach (pm[i]) begin
			ld(pm[i]);
			issue(csf_pkg::OP_MUL, 8'hC8, 8'h0F);
			`CHK({res_hi_o, res_o}, 16'h0BB8)
			issue(csf_pkg::OP_DIV, 8'hC8, 8'h0F);
			`CHK({res_hi_o, res_o}, 16'h050D)
			`CHK(psw_o, pm[i])
		end
		foreach (fo[i]) begin
			ld(8'h08);
			issue(csf_pkg::OP_ADC, 8'h12, 8'h34);
			issue(fo[i][7:4], 8'h00, 8'h00);
			`CHK(dec_hazard_o, 1'b1)
			ld(8'h08);
			issue(csf_pkg::OP_SBC, 8'h12, 8'h34);
			issue(csf_pkg::OP_NOP, 8'h00, 8'h00);
			issue(fo[i][7:4], 8'h00, 8'h00);
			`CHK(dec_hazard_o, 1'b0)
			`CHK(psw_o[fo[i][3:1]], fo[i][0])
		end
		ld(8'h00);
		issue(csf_pkg::OP_ADC, 8'h80, 8'h80);
		`CHK(psw_o, 8'h43)
		issue(csf_pkg::OP_SED, 8'h00, 8'h00);
		`CHK(psw_o[csf_pkg::FLG_D], 1'b1)
		issue(csf_pkg::OP_DIV, 8'h37, 8'h00);
		`CHK({res_hi_o, res_o}, 16'h37FF)
		`CHK(psw_o, 8'h4B)
		idle();
		irq_wr_i = 8'hA5;
		issue(csf_pkg::OP_IRQW, 8'h00, 8'h00);
		`CHK(irq_req_o, 8'h00)
		idle();
		`CHK(irq_req_o, 8'hA5)
		irq_set_i = 8'h40;
		idle();
		irq_set_i = 8'h00;
		repeat (2) idle();
		`CHK(irq_req_o, 8'hE5)
		irq_wr_i = 8'h00;
		issue(csf_pkg::OP_IRQW, 8'h00, 8'h00);
		irq_set_i = 8'h02;
		idle();
		irq_set_i = 8'h00;
		`CHK(irq_req_o, 8'h02)
		`CHK(done_o, 1'b0)
		for (int m = 0; m < 2; m++) begin
			high_speed_i = m[0];
			idle();
			n = 0;
			repeat (8) begin
				p = phi_o;
				idle();
				if (phi_o !== p) n++;
			end
			`CHK(n, m * 16 / int'(csf_pkg::CLK_DIV_HS))
		end
		ld(8'h00);
		`CHK(psw_o, 8'h00)
		rst_n_i = 1'b0;
		idle();
		rst_n_i = 1'b1;
		`CHK(psw_o[csf_pkg::FLG_I], 1'b1)
		`CHK({res_o, irq_req_o}, 16'h0000)
		give_verdict();
	end
endmodule : csf_core_test
`default_nettype wire
